// *** src/pwmis_core.sv ***
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pwmis_defines.svh"


module pwmis_core
    import pwmis_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0]       addr,
    input  wire logic [31:0]             wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [31:0]             rd_data,
    // Timer events, one-cycle pulses
    input  wire logic [`PWMIS_NUM_CH-1:0] timer_stop_event,
    input  wire logic [`PWMIS_NUM_CH-1:0] timer_zero_event,
    input  wire logic [`PWMIS_NUM_CH-1:0] timer_period_end_event,
    // Operator events, one-cycle pulses
    input  wire logic [`PWMIS_NUM_CH-1:0] operator_compare_a_event,
    input  wire logic [`PWMIS_NUM_CH-1:0] operator_compare_b_event,
    // Trip and capture events, one-cycle pulses
    input  wire logic [`PWMIS_NUM_CH-1:0] cycle_by_cycle_trip,
    input  wire logic [`PWMIS_NUM_CH-1:0] one_shot_trip,
    input  wire logic [`PWMIS_NUM_CH-1:0] capture_event,
    // Asynchronous fault levels, high while a fault is present
    input  wire logic [`PWMIS_NUM_CH-1:0] fault_input,
    // Interrupt request
    output logic                         irq
);

    // ****************************************
    // Declarations
    // ****************************************
    pwmis_sel_t                 sel;
    pwmis_vec_t                 ena;
    pwmis_vec_t                 raw;
    pwmis_vec_t                 masked;
    pwmis_vec_t                 set_vec;
    pwmis_vec_t                 clr_vec;
    pwmis_vec_t                 next_raw;
    logic [`PWMIS_NUM_CH-1:0]   flt_start;
    logic [`PWMIS_NUM_CH-1:0]   flt_end;

    // ****************************************
    // Fault edge detection
    // ****************************************
    pwmis_fault_edge #(
        .N           (`PWMIS_NUM_CH)
    ) u_fault_edge (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .fault_pin   (fault_input),
        .start_pulse (flt_start),
        .end_pulse   (flt_end)
    );

    // ****************************************
    // Address decode
    // ****************************************
    always_comb begin
        case (addr)
            ADDR_W'(`PWMIS_OFF_ENA):    sel = PWMIS_SEL_ENA;
            ADDR_W'(`PWMIS_OFF_RAW):    sel = PWMIS_SEL_RAW;
            ADDR_W'(`PWMIS_OFF_MASKED): sel = PWMIS_SEL_MASKED;
            ADDR_W'(`PWMIS_OFF_CLR):    sel = PWMIS_SEL_CLR;
            default:                    sel = PWMIS_SEL_NONE;
        endcase
    end

    // ****************************************
    // Enable register
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ena <= `PWMIS_RST_ENA;
        end else if (wr_en && sel == PWMIS_SEL_ENA) begin
            ena <= wr_data[`PWMIS_NUM_SRC-1:0];
        end
    end

    // ****************************************
    // Raw status
    // ****************************************
    assign set_vec = {capture_event,
                      one_shot_trip,
                      cycle_by_cycle_trip,
                      operator_compare_b_event,
                      operator_compare_a_event,
                      flt_end,
                      flt_start,
                      timer_period_end_event,
                      timer_zero_event,
                      timer_stop_event};

    // Writes to the raw and masked words are ignored
    assign clr_vec = (wr_en && sel == PWMIS_SEL_CLR) ?
                     wr_data[`PWMIS_NUM_SRC-1:0] : '0;

    genvar b;
    generate
        for (b = 0; b < `PWMIS_NUM_SRC; b++) begin : g_raw
            // Set wins, so an event in the clearing cycle is kept
            assign next_raw[b] = set_vec[b] | (raw[b] & ~clr_vec[b]);
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    raw[b] <= 1'b0;
                end else begin
                    raw[b] <= next_raw[b];
                end
            end
        end
    endgenerate

    assign masked = raw & ena;

    // Combinational OR of raw & ena flops, not registered itself
    assign irq = |masked;

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= `PWMIS_RST_RDATA;
        end else if (rd_en) begin
            case (sel)
                PWMIS_SEL_ENA:    rd_data <= {2'b00, ena};
                PWMIS_SEL_RAW:    rd_data <= {2'b00, raw};
                PWMIS_SEL_MASKED: rd_data <= {2'b00, masked};
                default:          rd_data <= `PWMIS_RST_RDATA;
            endcase
        end else begin
            // Data stand only in the cycle after the strobe
            rd_data <= `PWMIS_RST_RDATA;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_ena_rw;
        logic [29:0] d;
        (wr_en && sel == PWMIS_SEL_ENA, d = wr_data[29:0])
        ##1 (rd_en && sel == PWMIS_SEL_ENA && !wr_en)
        |=> rd_data == {2'b00, d};
    endproperty
    a_ena_rw: assert property (p_ena_rw)
        else $error("enable word did not read back");

    property p_zero_ena;
        (wr_en && sel == PWMIS_SEL_ENA)
        |=> ena[`PWMIS_POS_ZERO +: 3] == $past(wr_data[5:3]);
    endproperty
    a_zero_ena: assert property (p_zero_ena)
        else $error("zero enable bits not stored");

    property p_stop_irq;
        (timer_stop_event[0] && ena[`PWMIS_POS_STOP]
         && !(wr_en && sel == PWMIS_SEL_ENA))
        |=> irq;
    endproperty
    a_stop_irq: assert property (p_stop_irq)
        else $error("enabled stop event gave no interrupt");

    property p_cap_set;
        capture_event[2] |=> raw[`PWMIS_POS_CAP + 2];
    endproperty
    a_cap_set: assert property (p_cap_set)
        else $error("capture 2 flag not set");

    property p_ost_set;
        one_shot_trip[1] |=> raw[`PWMIS_POS_OST + 1];
    endproperty
    a_ost_set: assert property (p_ost_set)
        else $error("one-shot trip flag not set");

    property p_cbc_set;
        cycle_by_cycle_trip[0] |=> raw[`PWMIS_POS_CBC];
    endproperty
    a_cbc_set: assert property (p_cbc_set)
        else $error("cycle-by-cycle trip flag not set");

    property p_cmp_b_set;
        operator_compare_b_event[2] |=> raw[`PWMIS_POS_CMP_B + 2];
    endproperty
    a_cmp_b_set: assert property (p_cmp_b_set)
        else $error("compare B flag not set");

    property p_cmp_a_set;
        operator_compare_a_event[1] |=> raw[`PWMIS_POS_CMP_A + 1];
    endproperty
    a_cmp_a_set: assert property (p_cmp_a_set)
        else $error("compare A flag not set");

    property p_flt_start;
        $rose(fault_input[0]) ##1 fault_input[0] ##1 fault_input[0]
        |-> ##[0:2] raw[`PWMIS_POS_FLT_START];
    endproperty
    a_flt_start: assert property (p_flt_start)
        else $error("fault start flag not set");

    property p_flt_end;
        $fell(fault_input[0]) ##1 !fault_input[0] ##1 !fault_input[0]
        |-> ##[0:2] raw[`PWMIS_POS_FLT_END];
    endproperty
    a_flt_end: assert property (p_flt_end)
        else $error("fault end flag not set");

    property p_period_set;
        timer_period_end_event[1] |=> raw[`PWMIS_POS_PERIOD + 1];
    endproperty
    a_period_set: assert property (p_period_set)
        else $error("period-end flag not set");

    property p_masked_read;
        (rd_en && sel == PWMIS_SEL_MASKED)
        |=> rd_data == {2'b00, $past(raw) & $past(ena)};
    endproperty
    a_masked_read: assert property (p_masked_read)
        else $error("masked word does not match raw and enable");

    property p_clear;
        (wr_en && sel == PWMIS_SEL_CLR && wr_data[`PWMIS_POS_CAP]
         && !capture_event[0])
        |=> !raw[`PWMIS_POS_CAP];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear write left capture 0 flag set");

    property p_set_wins;
        (wr_en && sel == PWMIS_SEL_CLR && wr_data[`PWMIS_POS_OST]
         && one_shot_trip[0])
        |=> raw[`PWMIS_POS_OST];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing cycle");

    property p_hold;
        (raw[`PWMIS_POS_ZERO] && !(wr_en && sel == PWMIS_SEL_CLR))
        |=> raw[`PWMIS_POS_ZERO] [*1];
    endproperty
    a_hold: assert property (p_hold)
        else $error("raw flag dropped without a clear");

    property p_irq_off;
        (ena == '0) [*2] |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised with all enables off");

    property p_period_ena;
        (wr_en && sel == PWMIS_SEL_ENA)
        |=> ena[`PWMIS_POS_PERIOD +: 3] == $past(wr_data[8:6]);
    endproperty
    a_period_ena: assert property (p_period_ena)
        else $error("period-end enable bits not stored");

    property p_stop_ena;
        (wr_en && sel == PWMIS_SEL_ENA)
        |=> ena[`PWMIS_POS_STOP +: 3] == $past(wr_data[2:0]);
    endproperty
    a_stop_ena: assert property (p_stop_ena)
        else $error("stop enable bits not stored");

    property p_ena_hold;
        !(wr_en && sel == PWMIS_SEL_ENA) |=> $stable(ena);
    endproperty
    a_ena_hold: assert property (p_ena_hold)
        else $error("enable word changed without a write");

    property p_raw_ro;
        (wr_en && sel == PWMIS_SEL_RAW && set_vec == '0)
        |=> raw == $past(raw);
    endproperty
    a_raw_ro: assert property (p_raw_ro)
        else $error("write to raw word changed a flag");

    property p_cap_quiet;
        (!raw[`PWMIS_POS_CAP] && !capture_event[0])
        |=> !raw[`PWMIS_POS_CAP];
    endproperty
    a_cap_quiet: assert property (p_cap_quiet)
        else $error("capture 0 flag set without an event");

    property p_clr_keep;
        (wr_en && sel == PWMIS_SEL_CLR && raw[`PWMIS_POS_CAP]
         && !wr_data[`PWMIS_POS_CAP])
        |=> raw[`PWMIS_POS_CAP];
    endproperty
    a_clr_keep: assert property (p_clr_keep)
        else $error("clear write hit an unselected flag");

    property p_clr_rd;
        (rd_en && sel == PWMIS_SEL_CLR) |=> rd_data == '0;
    endproperty
    a_clr_rd: assert property (p_clr_rd)
        else $error("write-only clear word read nonzero");

    // Zero between reads keeps a stale word off the bus
    property p_rd_idle;
        !rd_en |=> rd_data == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data stood beyond its cycle");

    c_masked_irq: cover property (
        capture_event[0] && ena[`PWMIS_POS_CAP] ##1 irq);
    c_clear_irq: cover property (
        irq ##1 (wr_en && sel == PWMIS_SEL_CLR) ##1 !irq);
    c_fault_cycle: cover property (
        raw[`PWMIS_POS_FLT_START] && raw[`PWMIS_POS_FLT_END]);
    c_set_wins: cover property (
        wr_en && sel == PWMIS_SEL_CLR && |(set_vec & clr_vec));
    c_stop_irq: cover property (
        timer_stop_event[0] && ena[`PWMIS_POS_STOP] ##1 irq);

endmodule : pwmis_core

`default_nettype wire

// *** include/pwmis_defines.svh ***
`ifndef PWMIS_DEFINES_SVH
`define PWMIS_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PWMIS_OFF_ENA        12'h110
`define PWMIS_OFF_RAW        12'h114
`define PWMIS_OFF_MASKED     12'h118
`define PWMIS_OFF_CLR        12'h11C

// ****************************************
// Channel and source counts, field positions (lowest bit of each group of three)
// ****************************************
`define PWMIS_NUM_CH         3
`define PWMIS_NUM_SRC        30
`define PWMIS_POS_STOP       0
`define PWMIS_POS_ZERO       3
`define PWMIS_POS_PERIOD     6
`define PWMIS_POS_FLT_START  9
`define PWMIS_POS_FLT_END    12
`define PWMIS_POS_CMP_A      15
`define PWMIS_POS_CMP_B      18
`define PWMIS_POS_CBC        21
`define PWMIS_POS_OST        24
`define PWMIS_POS_CAP        27

// ****************************************
// Reset values
// ****************************************
`define PWMIS_RST_ENA        30'h00000000
`define PWMIS_RST_RAW        30'h00000000
`define PWMIS_RST_RDATA      32'h00000000

`endif

// *** include/pwmis_pkg.sv ***
`include "pwmis_defines.svh"

package pwmis_pkg;

    typedef logic [`PWMIS_NUM_SRC-1:0] pwmis_vec_t;

    typedef enum {
        PWMIS_SEL_ENA,
        PWMIS_SEL_RAW,
        PWMIS_SEL_MASKED,
        PWMIS_SEL_CLR,
        PWMIS_SEL_NONE
    } pwmis_sel_t;

endpackage : pwmis_pkg

// *** src/pwmis_fault_edge.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwmis_fault_edge #(
    parameter int N = 3
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // Asynchronous fault pins
    input  wire logic [N-1:0] fault_pin,
    // One-cycle pulses on start and end of each fault
    output logic      [N-1:0] start_pulse,
    output logic      [N-1:0] end_pulse
);

    logic [N-1:0] sync_a;
    logic [N-1:0] sync_b;
    logic [N-1:0] level_q;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            // Only sync_b reads sync_a; edges are taken after the pair
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync_a[i]      <= 1'b0;
                    sync_b[i]      <= 1'b0;
                    level_q[i]     <= 1'b0;
                    start_pulse[i] <= 1'b0;
                    end_pulse[i]   <= 1'b0;
                end else begin
                    sync_a[i]      <= fault_pin[i];
                    sync_b[i]      <= sync_a[i];
                    level_q[i]     <= sync_b[i];
                    start_pulse[i] <= sync_b[i] & ~level_q[i];
                    end_pulse[i]   <= ~sync_b[i] & level_q[i];
                end
            end
        end
    endgenerate

endmodule : pwmis_fault_edge

`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwmis_defines.svh"

module tb_top
    import pwmis_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk;
    logic        reset_n;
    logic [11:0] addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        irq;
    pwmis_vec_t  ev;
    pwmis_vec_t  exp_raw;
    logic [2:0]  fault_input;
    int          failures;
    int          checked;

    pwmis_core uut (
        .sys_clk                  (sys_clk),
        .reset_n                  (reset_n),
        .addr                     (addr),
        .wr_data                  (wr_data),
        .wr_en                    (wr_en),
        .rd_en                    (rd_en),
        .rd_data                  (rd_data),
        .timer_stop_event         (ev[`PWMIS_POS_STOP +: 3]),
        .timer_zero_event         (ev[`PWMIS_POS_ZERO +: 3]),
        .timer_period_end_event   (ev[`PWMIS_POS_PERIOD +: 3]),
        .operator_compare_a_event (ev[`PWMIS_POS_CMP_A +: 3]),
        .operator_compare_b_event (ev[`PWMIS_POS_CMP_B +: 3]),
        .cycle_by_cycle_trip      (ev[`PWMIS_POS_CBC +: 3]),
        .one_shot_trip            (ev[`PWMIS_POS_OST +: 3]),
        .capture_event            (ev[`PWMIS_POS_CAP +: 3]),
        .fault_input              (fault_input),
        .irq                      (irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic cmp_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_bit

    task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
    endtask : bus_write

    // Data stand only in the cycle after the strobe
    task automatic chk_read(input logic [11:0] a, input string n,
                            input logic [31:0] e);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        cmp_word(n, e, rd_data);
    endtask : chk_read

    // Write, then read in the very next cycle with no idle gap
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                         input string n, input logic [31:0] e);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge sys_clk);
        rd_en   <= 1'b0;
        #1;
        cmp_word(n, e, rd_data);
        @(posedge sys_clk);
        #1;
        cmp_word({n, " idle"}, 32'h00000000, rd_data);
    endtask : wr_rd

    task automatic pulse(input int idx);
        @(posedge sys_clk);
        ev[idx] <= 1'b1;
        @(posedge sys_clk);
        ev[idx] <= 1'b0;
    endtask : pulse

    task automatic fault_step(input int c, input logic lvl, input int pos);
        @(posedge sys_clk);
        fault_input[c] <= lvl;
        // Two sync flops plus edge detect, with margin
        repeat (6) @(posedge sys_clk);
        exp_raw[pos + c] = 1'b1;
        chk_read(`PWMIS_OFF_RAW, "raw fault", {2'h0, exp_raw});
    endtask : fault_step

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        failures    = 0;
        checked     = 0;
        reset_n     = 1'b0;
        addr        = 12'h000;
        wr_data     = 32'h00000000;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        ev          = '0;
        exp_raw     = '0;
        fault_input = 3'h0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;

        chk_read(`PWMIS_OFF_ENA, "enable rst", 32'h00000000);
        chk_read(`PWMIS_OFF_RAW, "raw rst", 32'h00000000);
        bus_write(`PWMIS_OFF_ENA, 32'hFFFFFFFF);
        chk_read(`PWMIS_OFF_ENA, "enable", 32'h3FFFFFFF);
        bus_write(`PWMIS_OFF_ENA, 32'h00000145);
        chk_read(`PWMIS_OFF_ENA, "enable", 32'h00000145);
        wr_rd(`PWMIS_OFF_ENA, 32'h00000092,
              "enable b2b", 32'h00000092);
        bus_write(`PWMIS_OFF_ENA, 32'h00000000);
        $display("Test enable done");

        // Every pulse source, one channel at a time, all masked
        for (int g = 0; g < 10; g++) begin
            if (g == 3 || g == 4) continue;
            for (int c = 0; c < 3; c++) begin
                pulse(g * 3 + c);
                exp_raw[g * 3 + c] = 1'b1;
                chk_read(`PWMIS_OFF_RAW, "raw", {2'h0, exp_raw});
                cmp_bit("irq masked", 1'b0, irq);
            end
        end
        $display("Test events done");

        for (int c = 0; c < 3; c++) begin
            fault_step(c, 1'b1, `PWMIS_POS_FLT_START);
            fault_step(c, 1'b0, `PWMIS_POS_FLT_END);
        end
        bus_write(`PWMIS_OFF_RAW, 32'h00000000);
        chk_read(`PWMIS_OFF_RAW, "raw ro", 32'h3FFFFFFF);
        $display("Test faults done");

        bus_write(`PWMIS_OFF_ENA, 32'h15555555);
        chk_read(`PWMIS_OFF_MASKED, "masked", 32'h15555555);
        cmp_bit("irq", 1'b1, irq);
        bus_write(`PWMIS_OFF_CLR, 32'h0000FFFF);
        chk_read(`PWMIS_OFF_RAW, "raw clr", 32'h3FFF0000);
        chk_read(`PWMIS_OFF_MASKED, "masked", 32'h15550000);
        bus_write(`PWMIS_OFF_ENA, 32'h0000AAAA);
        chk_read(`PWMIS_OFF_MASKED, "masked", 32'h00000000);
        cmp_bit("irq", 1'b0, irq);
        bus_write(`PWMIS_OFF_ENA, 32'h3FFFFFFF);
        bus_write(`PWMIS_OFF_CLR, 32'h3FFF0000);
        chk_read(`PWMIS_OFF_RAW, "raw clr", 32'h00000000);
        cmp_bit("irq", 1'b0, irq);
        $display("Test mask and clear done");

        // Event and clear in one cycle: the set must win
        fork
            pulse(`PWMIS_POS_OST);
            bus_write(`PWMIS_OFF_CLR, 32'h3FFFFFFF);
        join
        chk_read(`PWMIS_OFF_RAW, "raw set wins", 32'h01000000);
        cmp_bit("irq set wins", 1'b1, irq);
        pulse(`PWMIS_POS_STOP);
        chk_read(`PWMIS_OFF_MASKED, "masked stop", 32'h01000001);
        bus_write(`PWMIS_OFF_CLR, 32'h01000001);
        chk_read(`PWMIS_OFF_RAW, "raw clr", 32'h00000000);
        cmp_bit("irq", 1'b0, irq);
        $display("Test set wins done");

        // Writes that must land nowhere
        bus_write(`PWMIS_OFF_MASKED, 32'h00000000);
        bus_write(12'h120, 32'h00000000);
        chk_read(`PWMIS_OFF_ENA, "enable kept", 32'h3FFFFFFF);
        chk_read(`PWMIS_OFF_CLR, "clear wo", 32'h00000000);
        chk_read(12'h200, "unmapped", 32'h00000000);
        $display("Test decode done");
        summarize();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        $display("[ERR] watchdog expected end seen hang");
        summarize();
    end
endmodule : tb_top

`default_nettype wire
